// >>> core/nvac_ctrl.sv
`timescale 1ns/1ns
`include "nvac_regs.svh"
module nvac_ctrl #(
   parameter int READ_CYCLES = `NVAC_READ_CYCLES,
   parameter int WRITE_TICKS = `NVAC_WRITE_TICKS
) (
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic                   ce,
   input  wire nvac_pkg::nvac_sfr_req_t sfr_req,
   output logic      [7:0]             sfr_rdata,
   input  wire logic                   nv_timer_osc,
   input  wire logic                   stack_full,
   input  wire logic                   irq_serviced,
   output logic                        irq_req,
   output logic                        nv_busy
);
   nvac_pkg::nvac_state_t s_q;
   nvac_pkg::nvac_state_t s_d;

   logic                   mem_rd;
   logic                   mem_wr;
   logic [`NVAC_IDX_W-1:0] mem_addr;
   logic [7:0]             mem_rdata;
   logic                   tmr_start;
   logic                   tmr_done;
   logic [15:0]            eff;
   logic                   rd_acc;
   logic                   wr_acc;
   logic                   idle;
   logic                   prog_ok;
   logic                   fetch_ok;

   // indirect ports steer through their pointer pair; all else is direct
   // pointer based reach
   function automatic logic [15:0] nvac_eff_addr(input logic [8:0]         a,
                                                 input nvac_pkg::nvac_state_t st);
      logic [15:0] r;
      r = {7'h00, a};
      if (a == {1'b0, `NVAC_INDIRECT_PORT1_OFS})
         r = {st.p1_sector, st.p1_low};
      else if (a == {1'b0, `NVAC_INDIRECT_PORT2_OFS})
         r = {st.p2_sector, st.p2_low};
      return r;
   endfunction : nvac_eff_addr

   function automatic logic nvac_hit(input logic [15:0] e,
                                     input logic [7:0]  sector,
                                     input logic [7:0]  ofs);
      return e == {sector, ofs};
   endfunction : nvac_hit

   function automatic logic [7:0] nvac_ctl_byte(input nvac_pkg::nvac_ctl_t c);
      logic [7:0] b;
      b                     = 8'h00;
      b[`NVAC_CTL_PPERMIT]  = c.prog_permit;
      b[`NVAC_CTL_PSTART]   = c.prog_start;
      b[`NVAC_CTL_FPERMIT]  = c.fetch_permit;
      b[`NVAC_CTL_FSTART]   = c.fetch_start;
      return b;
   endfunction : nvac_ctl_byte

   // an indirect port pointing at itself reads zero: no entry decodes it
   function automatic logic [7:0] nvac_read(input logic [15:0]          e,
                                            input nvac_pkg::nvac_state_t st);
      logic [7:0] v;
      v = 8'h00;
      if (nvac_hit(e, `NVAC_SECTOR1, `NVAC_CTL_OFS))
         v = nvac_ctl_byte(st.ctl);
      else if (nvac_hit(e, `NVAC_SECTOR0, `NVAC_IDX_OFS))
         v = {2'h0, st.idx};
      else if (nvac_hit(e, `NVAC_SECTOR0, `NVAC_VAL_OFS))
         v = st.val;
      else if (nvac_hit(e, `NVAC_SECTOR0, `NVAC_P1LOW_OFS))
         v = st.p1_low;
      else if (nvac_hit(e, `NVAC_SECTOR0, `NVAC_P1SEC_OFS))
         v = st.p1_sector;
      else if (nvac_hit(e, `NVAC_SECTOR0, `NVAC_P2LOW_OFS))
         v = st.p2_low;
      else if (nvac_hit(e, `NVAC_SECTOR0, `NVAC_P2SEC_OFS))
         v = st.p2_sector;
      else if (nvac_hit(e, `NVAC_SECTOR0, `NVAC_INTC_OFS))
      begin
         v[`NVAC_INTC_GLOBAL] = st.global_allow;
         v[`NVAC_INTC_ALLOW]  = st.done_allow;
         v[`NVAC_INTC_FLAG]   = st.done_flag;
      end
      return v;
   endfunction : nvac_read

   assign eff    = nvac_eff_addr(sfr_req.addr, s_q);
   assign rd_acc = sfr_req.sel && !sfr_req.we;
   assign wr_acc = sfr_req.sel && sfr_req.we;
   assign idle   = (s_q.phase == nvac_pkg::NVAC_IDLE);

   // a start only counts against the permit already stored, so a single
   // write of permit plus start cannot launch anything
   // permit must precede start
   assign prog_ok  = sfr_req.wdata[`NVAC_CTL_PSTART] && s_q.ctl.prog_permit
                     && !sfr_req.wdata[`NVAC_CTL_FSTART] && idle;
   assign fetch_ok = sfr_req.wdata[`NVAC_CTL_FSTART] && s_q.ctl.fetch_permit
                     && !sfr_req.wdata[`NVAC_CTL_PSTART] && idle;

   always_comb
   begin
      s_d       = s_q;
      mem_rd    = 1'b0;
      mem_wr    = 1'b0;
      tmr_start = 1'b0;
      mem_addr  = s_q.idx;

      if (rd_acc)
         s_d.rdata = nvac_read(eff, s_q);

      // register writes
      if (wr_acc)
      begin
         if (nvac_hit(eff, `NVAC_SECTOR1, `NVAC_CTL_OFS))
         begin
            s_d.ctl.prog_permit  = sfr_req.wdata[`NVAC_CTL_PPERMIT];
            s_d.ctl.fetch_permit = sfr_req.wdata[`NVAC_CTL_FPERMIT];
            // start bits are busy flags: software zeroes do not abort
            if (prog_ok)
            begin
               s_d.ctl.prog_start = 1'b1;
               s_d.phase          = nvac_pkg::NVAC_PROG;
               s_d.wr_addr        = s_q.idx;
               s_d.wr_data        = s_q.val;
               tmr_start          = 1'b1;
            end
            else if (fetch_ok)
            begin
               s_d.ctl.fetch_start = 1'b1;
               s_d.phase           = nvac_pkg::NVAC_FETCH;
               s_d.rd_cnt          = 4'(READ_CYCLES - 1);
               mem_rd              = 1'b1;
            end
         end
         // index and value frozen while busy
         else if (nvac_hit(eff, `NVAC_SECTOR0, `NVAC_IDX_OFS))
         begin
            if (idle)
               s_d.idx = sfr_req.wdata[`NVAC_IDX_W-1:0];
         end
         else if (nvac_hit(eff, `NVAC_SECTOR0, `NVAC_VAL_OFS))
         begin
            if (idle)
               s_d.val = sfr_req.wdata;
         end
         else if (nvac_hit(eff, `NVAC_SECTOR0, `NVAC_P1LOW_OFS))
            s_d.p1_low = sfr_req.wdata;
         else if (nvac_hit(eff, `NVAC_SECTOR0, `NVAC_P1SEC_OFS))
            s_d.p1_sector = sfr_req.wdata;
         else if (nvac_hit(eff, `NVAC_SECTOR0, `NVAC_P2LOW_OFS))
            s_d.p2_low = sfr_req.wdata;
         else if (nvac_hit(eff, `NVAC_SECTOR0, `NVAC_P2SEC_OFS))
            s_d.p2_sector = sfr_req.wdata;
         else if (nvac_hit(eff, `NVAC_SECTOR0, `NVAC_INTC_OFS))
         begin
            s_d.global_allow = sfr_req.wdata[`NVAC_INTC_GLOBAL];
            s_d.done_allow   = sfr_req.wdata[`NVAC_INTC_ALLOW];
            s_d.done_flag    = sfr_req.wdata[`NVAC_INTC_FLAG];
         end
      end

      if (irq_serviced)
         s_d.done_flag = 1'b0;

      case (s_q.phase)
         nvac_pkg::NVAC_IDLE:
         begin
            s_d.rd_cnt = 4'h0;
         end
         nvac_pkg::NVAC_FETCH:
         begin
            if (s_q.rd_cnt == 4'h0)
            begin
               s_d.val             = mem_rdata;
               s_d.ctl.fetch_start = 1'b0;
               s_d.phase           = nvac_pkg::NVAC_IDLE;
            end
            else
               s_d.rd_cnt = s_q.rd_cnt - 4'h1;
         end
         nvac_pkg::NVAC_PROG:
         begin
            if (tmr_done)
            begin
               mem_addr = s_q.wr_addr;
               mem_wr   = s_q.ctl.prog_permit;
               s_d.ctl.prog_start = 1'b0;
               s_d.phase          = nvac_pkg::NVAC_IDLE;
               s_d.done_flag      = 1'b1;
            end
         end
         default:
         begin
            s_d.phase = nvac_pkg::NVAC_IDLE;
         end
      endcase
   end

   // reset clears permits and pointer sectors
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         s_q              <= '0;
         s_q.idx          <= '0;
         s_q.val          <= `NVAC_BYTE_RST;
         s_q.p1_sector    <= `NVAC_SECTOR0;
         s_q.p2_sector    <= `NVAC_SECTOR0;
         s_q.phase        <= nvac_pkg::NVAC_IDLE;
      end
      else if (ce)
         s_q <= s_d;
   end

   nvac_mem #(
      .AW    (`NVAC_IDX_W),
      .DEPTH (`NVAC_DEPTH)
   ) u_mem (
      .clk   (clk),
      .ce    (ce),
      .rd_en (mem_rd),
      .wr_en (mem_wr),
      .addr  (mem_addr),
      .wdata (s_q.wr_data),
      .rdata (mem_rdata)
   );

   // the write time floats with the oscillator, software must poll or wait
   nvac_wtimer #(
      .TICKS (WRITE_TICKS)
   ) u_tmr (
      .clk   (clk),
      .reset (reset),
      .ce    (ce),
      .osc   (nv_timer_osc),
      .start (tmr_start),
      .done  (tmr_done)
   );

   assign irq_req   = s_q.done_flag && s_q.done_allow && s_q.global_allow && !stack_full;
   assign nv_busy   = !idle;
   assign sfr_rdata = s_q.rdata;
endmodule : nvac_ctrl

// >>> core/nvac_mem.sv
`timescale 1ns/1ns
module nvac_mem #(
   parameter int AW    = 6,
   parameter int DEPTH = 64
) (
   input  wire logic          clk,
   input  wire logic          ce,
   input  wire logic          rd_en,
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] addr,
   input  wire logic [7:0]    wdata,
   output logic      [7:0]    rdata
);
   typedef struct packed {
      logic [DEPTH-1:0][7:0] cells;
      logic [7:0]            rdata;
   } nvac_mem_state_t;

   nvac_mem_state_t s_q;
   nvac_mem_state_t s_d;

   always_comb
   begin
      s_d = s_q;
      if (rd_en)
         s_d.rdata = s_q.cells[addr];
      if (wr_en)
         s_d.cells[addr] = wdata;
   end

   // no reset: contents must outlive it
   // persistent array
   always_ff @(posedge clk)
   begin
      if (ce)
         s_q <= s_d;
   end

   assign rdata = s_q.rdata;
endmodule : nvac_mem

// >>> core/nvac_pkg.sv
`include "nvac_regs.svh"
package nvac_pkg;
   // one register access from the core
   typedef struct packed {
      logic       sel;
      logic       we;
      logic [8:0] addr;
      logic [7:0] wdata;
   } nvac_sfr_req_t;

   typedef struct packed {
      logic prog_permit;
      logic prog_start;
      logic fetch_permit;
      logic fetch_start;
   } nvac_ctl_t;

   typedef enum logic [1:0] {NVAC_IDLE, NVAC_FETCH, NVAC_PROG} nvac_phase_t;

   typedef struct packed {
      nvac_ctl_t                ctl;
      logic [`NVAC_IDX_W-1:0]   idx;
      logic [7:0]               val;
      logic [7:0]               p1_sector;
      logic [7:0]               p1_low;
      logic [7:0]               p2_sector;
      logic [7:0]               p2_low;
      logic                     global_allow;
      logic                     done_allow;
      logic                     done_flag;
      nvac_phase_t              phase;
      logic [3:0]               rd_cnt;
      logic [`NVAC_IDX_W-1:0]   wr_addr;
      logic [7:0]               wr_data;
      logic [7:0]               rdata;
   } nvac_state_t;
endpackage : nvac_pkg

// >>> core/nvac_regs.svh
`ifndef NVAC_REGS_SVH
`define NVAC_REGS_SVH
// Function
// - sixty-four byte storage addressed 0x00 to 0x3F by six address bits.
// - every access moves one byte via index, value and control registers.
// - control register sits at sector 1 offset 0x40, reached directly at 0x140 or through pointers.
// - index register holds bits 5..0, resets zero, bits 7..6 read zero.
// - value register is eight bits read/write, resets zero.
// - control bits: 3 program permit, 2 program start, 1 fetch permit, 0 fetch start.
// - program permit low blocks every write into the array.
// - program start begins a write only when permit was already one.
// - hardware clears program start when the write cycle ends.
// - fetch start begins a read only when fetch permit is one.
// - hardware clears fetch start at read end, byte now in value register.
// - fetched byte holds until software starts another operation.
// - write cycle timed by a timer asynchronous to the system clock.
// - reset clears program permit and pointer sectors, selecting sector 0.
// - write end sets the done request flag regardless of polling.
// - vector request needs done allow, global allow and stack not full.
// - servicing the done interrupt clears its request flag.
`define NVAC_SECTOR0      8'h00
`define NVAC_SECTOR1      8'h01
`define NVAC_CTL_OFS      8'h40
`define NVAC_INDIRECT_PORT1_OFS     8'h02
`define NVAC_P1LOW_OFS    8'h03
`define NVAC_P1SEC_OFS    8'h04
`define NVAC_INDIRECT_PORT2_OFS     8'h05
`define NVAC_P2LOW_OFS    8'h06
`define NVAC_P2SEC_OFS    8'h07
`define NVAC_INTC_OFS     8'h0E
`define NVAC_IDX_OFS      8'h1A
`define NVAC_VAL_OFS      8'h1B
`define NVAC_CTL_PPERMIT  3
`define NVAC_CTL_PSTART   2
`define NVAC_CTL_FPERMIT  1
`define NVAC_CTL_FSTART   0
`define NVAC_INTC_GLOBAL  0
`define NVAC_INTC_ALLOW   1
`define NVAC_INTC_FLAG    2
`define NVAC_IDX_W        6
`define NVAC_DEPTH        64
`define NVAC_BYTE_RST     8'h00
`define NVAC_READ_CYCLES  4
`define NVAC_WRITE_TICKS  32
`endif

// >>> core/nvac_wtimer.sv
`timescale 1ns/1ns
module nvac_wtimer #(
   parameter int TICKS = 32
) (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic ce,
   input  wire logic osc,
   input  wire logic start,
   output logic      done
);
   localparam int TW = $clog2(TICKS + 1);

   typedef struct packed {
      logic          sync_a;
      logic          sync_b;
      logic          prev;
      logic          run;
      logic [TW-1:0] ticks;
      logic          done;
   } nvac_tmr_state_t;

   nvac_tmr_state_t s_q;
   nvac_tmr_state_t s_d;

   always_comb
   begin
      s_d        = s_q;
      s_d.done   = 1'b0;
      s_d.sync_a = osc;
      s_d.sync_b = s_q.sync_a;
      s_d.prev   = s_q.sync_b;
      if (start)
      begin
         s_d.run   = 1'b1;
         s_d.ticks = '0;
      end
      // counts rising edges of the free oscillator
      else if (s_q.run && s_q.sync_b && !s_q.prev)
      begin
         if (s_q.ticks == TW'(TICKS - 1))
         begin
            s_d.run  = 1'b0;
            s_d.done = 1'b1;
         end
         else
            s_d.ticks = s_q.ticks + TW'(1);
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         s_q <= '0;
      else if (ce)
         s_q <= s_d;
   end

   assign done = s_q.done;
endmodule : nvac_wtimer

// >>> tb/nvac_core_model.sv
`timescale 1ns/1ns
module nvac_core_model (
   input  wire logic                   clk,
   output nvac_pkg::nvac_sfr_req_t     sfr_req,
   input  wire logic [7:0]             sfr_rdata,
   output logic                        nv_timer_osc
);
   initial
   begin
      sfr_req = '0;
      nv_timer_osc = 1'b0;
   end
   // free running, phase unrelated to clk
   always #11 nv_timer_osc = ~nv_timer_osc;
   // core never sleeps: bus stays clocked through every cycle
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_req = '{1'b1, 1'b1, a, d};
      @(negedge clk);
      sfr_req = '{1'b0, 1'b0, ~a, ~d};
   endtask : wr
   task automatic rd(input logic [8:0] a, output logic [7:0] d);
      @(negedge clk);
      sfr_req = '{1'b1, 1'b0, a, 8'h00};
      @(negedge clk);
      sfr_req = '{1'b0, 1'b0, ~a, 8'hFF};
      d = sfr_rdata;
   endtask : rd
endmodule : nvac_core_model

// >>> tb/nvac_ctrl_monitor.sv
`timescale 1ns/1ns
module nvac_ctrl_monitor #(
   parameter int READ_CYCLES = 4,
   parameter int WRITE_TICKS = 32
) (
   input wire logic                    clk,
   input wire logic                    reset,
   input wire logic                    ce,
   input wire nvac_pkg::nvac_sfr_req_t sfr_req,
   input wire logic [7:0]              sfr_rdata,
   input wire logic                    nv_timer_osc,
   input wire logic                    stack_full,
   input wire logic                    irq_serviced,
   input wire logic                    irq_req,
   input wire logic                    nv_busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   wire logic rd_s = sfr_req.sel && !sfr_req.we;
   wire logic wr_s = sfr_req.sel && sfr_req.we;

   property p_stack; irq_req |-> !stack_full; endproperty
   a_stack: assert property (p_stack) else $error("irq with stack full");
   property p_irq_cause;
      $rose(irq_req) |-> $fell(nv_busy) || $past(wr_s) || $fell(stack_full);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
   property p_serviced;
      irq_req && irq_serviced && !nv_busy && !wr_s |=> !irq_req;
   endproperty
   a_serviced: assert property (p_serviced) else $error("flag not cleared");
   property p_busy_cause; $rose(nv_busy) |-> $past(wr_s); endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy without write");
   property p_fetch_len;
      $rose(nv_busy) && $past(sfr_req.wdata[0]) |-> nv_busy[*3] ##[1:4] !nv_busy;
   endproperty
   a_fetch_len: assert property (p_fetch_len) else $error("fetch length wrong");
   property p_wr_len;
      $rose(nv_busy) && $past(sfr_req.wdata[2]) |-> nv_busy[*5] ##[1:300] !nv_busy;
   endproperty
   a_wr_len: assert property (p_wr_len) else $error("write length wrong");
   property p_rdata_hold; $changed(sfr_rdata) |-> $past(rd_s); endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_ctl_hi; rd_s && sfr_req.addr == 9'h140 |=> sfr_rdata[7:4] == 4'h0; endproperty
   a_ctl_hi: assert property (p_ctl_hi) else $error("control high bits");
   property p_idx_hi; rd_s && sfr_req.addr == 9'h01A |=> sfr_rdata[7:6] == 2'h0; endproperty
   a_idx_hi: assert property (p_idx_hi) else $error("index high bits");
   property p_unmapped; rd_s && sfr_req.addr == 9'h1F0 |=> sfr_rdata == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
endmodule : nvac_ctrl_monitor

// >>> tb/nvac_ctrl_tb_top.sv
`timescale 1ns/1ns
module nvac_ctrl_tb_top;
   localparam int READ_CYCLES = 4;
   localparam int WRITE_TICKS = 2;
   localparam logic [8:0] ad_idx = 9'h01A, ad_val = 9'h01B, ad_ctl = 9'h140;
   localparam logic [8:0] ad_intc = 9'h00E, ad_indirect_port1 = 9'h002;
   logic                    clk = 1'b0;
   logic                    reset = 1'b1;
   logic                    stack_full = 1'b0;
   logic                    irq_serviced = 1'b0;
   logic                    irq_req;
   logic                    nv_busy;
   logic                    osc;
   logic [7:0]              rdata;
   nvac_pkg::nvac_sfr_req_t req;
   int                      n_fail = 0;
   int                      checked = 0;

   always #2 clk = ~clk;
   nvac_core_model core_u (.clk(clk), .sfr_req(req), .sfr_rdata(rdata), .nv_timer_osc(osc));
   nvac_ctrl #(.READ_CYCLES(READ_CYCLES), .WRITE_TICKS(WRITE_TICKS)) dut_u (
      .clk(clk), .reset(reset), .ce(1'b1), .sfr_req(req), .sfr_rdata(rdata),
      .nv_timer_osc(osc), .stack_full(stack_full), .irq_serviced(irq_serviced),
      .irq_req(irq_req), .nv_busy(nv_busy));

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic rc(input logic [8:0] a, input logic [7:0] e, input string nm);
      logic [7:0] v;
      core_u.rd(a, v);
      chk(nm, v, e);
   endtask : rc
   task automatic poll(input int b);
      logic [7:0] v;
      int         n;
      n = 0;
      v = 8'hFF;
      while (v[b] !== 1'b0 && n < 100)
      begin
         core_u.rd(ad_ctl, v);
         n++;
      end
      chk("start bit", {7'h00, v[b]}, 8'h00);
   endtask : poll
   task automatic final_report;
      if (n_fail == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report

   task automatic t_reset;
      rc(ad_idx, 8'h00, "index");
      rc(ad_val, 8'h00, "value");
      rc(ad_ctl, 8'h00, "control");
      rc(9'h004, 8'h00, "pointer1 sector");
      rc(9'h007, 8'h00, "pointer2 sector");
   endtask : t_reset
   task automatic t_fields;
      core_u.wr(ad_idx, 8'hFF);
      rc(ad_idx, 8'h3F, "index mask");
      core_u.wr(ad_val, 8'hA5);
      rc(ad_val, 8'hA5, "value rw");
      core_u.wr(ad_ctl, 8'hF2);
      rc(ad_ctl, 8'h02, "control mask");
      rc(9'h1F0, 8'h00, "unmapped");
      core_u.wr(9'h003, 8'h40);
      core_u.wr(9'h004, 8'h01);
      rc(ad_indirect_port1, 8'h02, "indirect control");
      core_u.wr(ad_indirect_port1, 8'h00);
      rc(ad_ctl, 8'h00, "indirect write");
   endtask : t_fields
   task automatic t_write(input logic [7:0] a, input logic [7:0] d);
      core_u.wr(ad_idx, a);
      core_u.wr(ad_val, d);
      // permit then start, global allow off
      core_u.wr(ad_intc, 8'h02);
      core_u.wr(ad_ctl, 8'h08);
      core_u.wr(ad_ctl, 8'h0C);
      chk("busy", {7'h00, nv_busy}, 8'h01);
      core_u.wr(ad_val, ~d);
      core_u.wr(ad_intc, 8'h03);
      poll(2);
      rc(ad_intc, 8'h07, "done flag");
      rc(ad_val, d, "value kept");
   endtask : t_write
   task automatic t_read(input logic [7:0] a, input logic [7:0] e);
      core_u.wr(ad_idx, a);
      core_u.wr(ad_ctl, 8'h02);
      core_u.wr(ad_ctl, 8'h03);
      poll(0);
      rc(ad_val, e, "fetched");
      core_u.wr(ad_idx, a ^ 8'h01);
      rc(ad_val, e, "fetched held");
   endtask : t_read
   task automatic t_irq;
      chk("irq", {7'h00, irq_req}, 8'h01);
      core_u.wr(ad_intc, 8'h05);
      chk("irq no allow", {7'h00, irq_req}, 8'h00);
      core_u.wr(ad_intc, 8'h07);
      @(negedge clk) stack_full = 1'b1;
      @(negedge clk) chk("irq stack", {7'h00, irq_req}, 8'h00);
      stack_full = 1'b0;
      @(negedge clk) irq_serviced = 1'b1;
      @(negedge clk) irq_serviced = 1'b0;
      chk("irq serviced", {7'h00, irq_req}, 8'h00);
      rc(ad_intc, 8'h03, "flag cleared");
   endtask : t_irq
   task automatic t_blocked;
      core_u.wr(ad_ctl, 8'h04);
      chk("no write", {7'h00, nv_busy}, 8'h00);
      rc(ad_ctl, 8'h00, "start ignored");
      core_u.wr(ad_ctl, 8'h01);
      chk("no fetch", {7'h00, nv_busy}, 8'h00);
      core_u.wr(ad_idx, 8'h3F);
      core_u.wr(ad_val, 8'h5A);
      core_u.wr(ad_ctl, 8'h08);
      core_u.wr(ad_ctl, 8'h0C);
      core_u.wr(ad_ctl, 8'h04);
      poll(2);
      t_read(8'h3F, 8'hC3);
   endtask : t_blocked

   initial
   begin
      repeat (5) @(negedge clk);
      reset = 1'b0;
      t_reset();
      t_fields();
      t_write(8'h3F, 8'hC3);
      t_read(8'h3F, 8'hC3);
      t_irq();
      t_write(8'h00, 8'h3C);
      t_read(8'h00, 8'h3C);
      t_blocked();
      final_report();
   end
   initial
   begin
      #100000;
      n_fail++;
      final_report();
   end
endmodule : nvac_ctrl_tb_top

bind nvac_ctrl nvac_ctrl_monitor #(.READ_CYCLES(READ_CYCLES), .WRITE_TICKS(WRITE_TICKS)) mon_u (
   .clk(clk), .reset(reset), .ce(ce), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
   .nv_timer_osc(nv_timer_osc), .stack_full(stack_full), .irq_serviced(irq_serviced),
   .irq_req(irq_req), .nv_busy(nv_busy));
